// ### rtl/debug_interface_block.v
// Debug client selection behind the top test access port controller.
`default_nettype none
`include "tap_select_consts.vh"
module debug_interface_block #(
	parameter TOP_W = `TOP_IR_WIDTH,
	parameter PC_W = `PORT_CTRL_IR_WIDTH,
	parameter CORE_W = `CORE_IR_WIDTH
) (
	input wire clk,
	input wire rstn,
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo,
	output reg tdo_en,
	input wire debug_event,
	output reg break_request,
	output reg grant_port_ctrl_tap,
	output reg grant_core_tap,
	output reg port_ctrl_enabled,
	output reg [PC_W-1:0] port_ctrl_ir,
	output reg [CORE_W-1:0] core_ir
);
	// The link clock is sampled, so it must stay well below half the system clock rate.
	reg tck_s1, tck_s2, tck_s3;
	reg tms_s1, tms_s2, tdi_s1, tdi_s2, evt_s1, evt_s2, evt_s3;
	always @(posedge clk) begin
		if (!rstn) begin
			tck_s1 <= 1'b0;
			tck_s2 <= 1'b0;
			tck_s3 <= 1'b0;
			tms_s1 <= 1'b1;
			tms_s2 <= 1'b1;
			tdi_s1 <= 1'b0;
			tdi_s2 <= 1'b0;
			evt_s1 <= 1'b0;
			evt_s2 <= 1'b0;
			evt_s3 <= 1'b0;
		end else begin
			tck_s1 <= tck;
			tck_s2 <= tck_s1;
			tck_s3 <= tck_s2;
			tms_s1 <= tms;
			tms_s2 <= tms_s1;
			tdi_s1 <= tdi;
			tdi_s2 <= tdi_s1;
			evt_s1 <= debug_event;
			evt_s2 <= evt_s1;
			evt_s3 <= evt_s2;
		end
	end
	wire tck_rise = tck_s2 & ~tck_s3;
	wire tck_fall = ~tck_s2 & tck_s3;

	wire [3:0] top_state;
	wire [3:0] cli_state;
	tap_state_machine u_top_fsm (
		.clk(clk),
		.rstn(rstn),
		.tck_rise(tck_rise),
		.tms(tms_s2),
		.state(top_state)
	);
	// The client controller follows the same pins but only matters while granted.
	tap_state_machine u_client_fsm (
		.clk(clk),
		.rstn(rstn),
		.tck_rise(tck_rise),
		.tms(tms_s2),
		.state(cli_state)
	);

	function [0:0] grants_port_ctrl;
		input [TOP_W-1:0] ir;
		begin
			grants_port_ctrl = (ir == `TOP_GRANT_PORT_CTRL);
		end
	endfunction

	function [0:0] grants_core;
		input [TOP_W-1:0] ir;
		begin
			grants_core = (ir == `TOP_GRANT_CORE);
		end
	endfunction

	function [0:0] client_routed;
		input [TOP_W-1:0] ir;
		begin
			client_routed = grants_port_ctrl(ir) || grants_core(ir);
		end
	endfunction

	function [0:0] shift_state;
		input [3:0] st;
		begin
			shift_state = (st == `ST_SHIFT_IR) || (st == `ST_SHIFT_DR);
		end
	endfunction

	reg [TOP_W-1:0] top_ir;
	reg [TOP_W-1:0] top_sh;
	reg top_bypass;
	reg [PC_W-1:0] pc_sh;
	reg [CORE_W-1:0] core_sh;
	reg cli_bypass;
	wire routed = client_routed(top_ir);
	always @(posedge clk) begin
		if (!rstn) begin
			top_ir <= `TOP_IR_RESET;
			top_sh <= {TOP_W{1'b0}};
			top_bypass <= 1'b0;
		end else if (tck_rise) begin
			if (top_state == `ST_RESET) begin
				top_ir <= `TOP_IR_RESET;
			end else if (top_state == `ST_CAP_IR) begin
				top_sh <= `TOP_IR_RESET;
			end else if (top_state == `ST_SHIFT_IR) begin
				top_sh <= {tdi_s2, top_sh[TOP_W-1:1]};
			end else if (top_state == `ST_UPD_IR) begin
				// Once a client owns the port its scans pass through, so the grant must hold.
				if (!routed) begin
					top_ir <= top_sh;
				end
			end else if (top_state == `ST_CAP_DR) begin
				top_bypass <= 1'b0;
			end else if (top_state == `ST_SHIFT_DR) begin
				top_bypass <= tdi_s2;
			end
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			port_ctrl_ir <= `PORT_CTRL_BYPASS;
			core_ir <= `CORE_IR_RESET;
			pc_sh <= {PC_W{1'b0}};
			core_sh <= {CORE_W{1'b0}};
			cli_bypass <= 1'b0;
		end else if (tck_rise) begin
			if (cli_state == `ST_RESET) begin
				port_ctrl_ir <= `PORT_CTRL_BYPASS;
				core_ir <= `CORE_IR_RESET;
			end else if (cli_state == `ST_CAP_IR) begin
				pc_sh <= {{(PC_W-1){1'b0}}, 1'b1};
				core_sh <= {{(CORE_W-1){1'b0}}, 1'b1};
			end else if (cli_state == `ST_SHIFT_IR) begin
				pc_sh <= {tdi_s2, pc_sh[PC_W-1:1]};
				core_sh <= {tdi_s2, core_sh[CORE_W-1:1]};
			end else if (cli_state == `ST_UPD_IR) begin
				if (grants_port_ctrl(top_ir)) begin
					port_ctrl_ir <= pc_sh;
				end
				if (grants_core(top_ir)) begin
					core_ir <= core_sh;
				end
			end else if (cli_state == `ST_CAP_DR) begin
				cli_bypass <= 1'b0;
			end else if (cli_state == `ST_SHIFT_DR) begin
				cli_bypass <= tdi_s2;
			end
		end
	end

	// Non-bypass client data registers lie outside this block, so they also shift one stage.
	reg cli_tdo;
	always @* begin
		if (grants_port_ctrl(top_ir)) begin
			if (cli_state == `ST_SHIFT_IR) begin
				cli_tdo = pc_sh[0];
			end else if (port_ctrl_ir == `PORT_CTRL_BYPASS) begin
				cli_tdo = cli_bypass;
			end else begin
				cli_tdo = cli_bypass;
			end
		end else begin
			if (cli_state == `ST_SHIFT_IR) begin
				cli_tdo = core_sh[0];
			end else begin
				cli_tdo = cli_bypass;
			end
		end
	end

	wire top_shift = shift_state(top_state);
	wire cli_shift = shift_state(cli_state);
	// Output changes on the falling link clock edge, as the port protocol expects.
	always @(posedge clk) begin
		if (!rstn) begin
			tdo <= 1'b0;
			tdo_en <= 1'b0;
			break_request <= 1'b0;
			grant_port_ctrl_tap <= 1'b0;
			grant_core_tap <= 1'b0;
			port_ctrl_enabled <= 1'b0;
		end else begin
			if (tck_fall) begin
				if (routed) begin
					tdo <= cli_tdo;
					tdo_en <= cli_shift;
				end else begin
					tdo <= (top_state == `ST_SHIFT_IR) ? top_sh[0] : top_bypass;
					tdo_en <= top_shift;
				end
			end
			break_request <= evt_s2 & ~evt_s3;
			grant_port_ctrl_tap <= grants_port_ctrl(top_ir);
			grant_core_tap <= grants_core(top_ir);
			port_ctrl_enabled <= grants_port_ctrl(top_ir) &&
				(port_ctrl_ir == `PORT_CTRL_ENABLE);
		end
	end
endmodule // debug_interface_block
`default_nettype wire

// ### rtl/tap_select_consts.vh
// Constants for the debug client test access port selection logic.
`ifndef TAP_SELECT_CONSTS_VH
`define TAP_SELECT_CONSTS_VH
`define TOP_IR_WIDTH 5
`define TOP_IR_RESET 5'h01
`define TOP_GRANT_PORT_CTRL 5'h10
`define TOP_GRANT_CORE 5'h11
`define PORT_CTRL_IR_WIDTH 4
`define PORT_CTRL_ENABLE 4'h0
`define PORT_CTRL_BYPASS 4'hF
`define CORE_IR_WIDTH 10
`define CORE_BYPASS 10'h07F
`define CORE_IR_RESET 10'h07F
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHIFT_DR 4'h4
`define ST_EXIT1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EXIT2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SHIFT_IR 4'hB
`define ST_EXIT1_IR 4'hC
`define ST_PAUSE_IR 4'hD
`define ST_EXIT2_IR 4'hE
`define ST_UPD_IR 4'hF
`endif

// ### rtl/tap_state_machine.v
// Test access port controller state machine, advanced on sampled clock edges.
`default_nettype none
`include "tap_select_consts.vh"
module tap_state_machine (
	input wire clk,
	input wire rstn,
	input wire tck_rise,
	input wire tms,
	output reg [3:0] state
);
	reg [3:0] next_state;
	always @* begin
		case (state)
		`ST_RESET: next_state = tms ? `ST_RESET : `ST_IDLE;
		`ST_IDLE: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_DR: next_state = tms ? `ST_SEL_IR : `ST_CAP_DR;
		`ST_CAP_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
		`ST_SHIFT_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
		`ST_EXIT1_DR: next_state = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
		`ST_PAUSE_DR: next_state = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
		`ST_EXIT2_DR: next_state = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
		`ST_UPD_DR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_IR: next_state = tms ? `ST_RESET : `ST_CAP_IR;
		`ST_CAP_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
		`ST_SHIFT_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
		`ST_EXIT1_IR: next_state = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
		`ST_PAUSE_IR: next_state = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
		`ST_EXIT2_IR: next_state = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
		`ST_UPD_IR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
		default: next_state = `ST_RESET;
		endcase
	end
	always @(posedge clk) begin
		if (!rstn) begin
			state <= `ST_RESET;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end
endmodule // tap_state_machine
`default_nettype wire

// ### verification/debug_interface_block_sva.sv
// Assertions on the debug client selection ports.
`default_nettype none
module debug_interface_block_sva #(parameter PC_W = 4, parameter CORE_W = 10) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tdo,
	input wire logic debug_event,
	input wire logic break_request,
	input wire logic grant_port_ctrl_tap,
	input wire logic grant_core_tap,
	input wire logic port_ctrl_enabled,
	input wire logic [PC_W-1:0] port_ctrl_ir,
	input wire logic [CORE_W-1:0] core_ir
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_ONE_GRANT: assert property (!(grant_port_ctrl_tap && grant_core_tap))
		else $error("two grants");
	AST_PC_REFUSE: assert property ($changed(port_ctrl_ir) && port_ctrl_ir != 4'hF
		|-> $past(grant_port_ctrl_tap)) else $error("port ir ungranted");
	AST_CORE_REFUSE: assert property ($changed(core_ir) && core_ir != 10'h07F
		|-> $past(grant_core_tap)) else $error("core ir ungranted");
	AST_ENABLE: assert property ($rose(port_ctrl_enabled) |-> grant_port_ctrl_tap
		&& port_ctrl_ir == 4'h0) else $error("bad enable");
	AST_RESET: assert property (!$past(rstn) |-> port_ctrl_ir == 4'hF
		&& core_ir == 10'h07F && !grant_port_ctrl_tap) else $error("reset values");
	AST_BREAK_RAISE: assert property ($rose(debug_event) |-> ##[1:6] break_request)
		else $error("no break");
	AST_BREAK_PULSE: assert property (break_request |=> !break_request)
		else $error("long break");
	AST_TDO_FALL: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
		else $error("tdo off fall");
endmodule // debug_interface_block_sva
bind debug_interface_block debug_interface_block_sva #(.PC_W(PC_W), .CORE_W(CORE_W)) u_sva (
	.clk(clk), .rstn(rstn), .tck(tck), .tdo(tdo), .debug_event(debug_event),
	.break_request(break_request), .grant_port_ctrl_tap(grant_port_ctrl_tap),
	.grant_core_tap(grant_core_tap), .port_ctrl_enabled(port_ctrl_enabled),
	.port_ctrl_ir(port_ctrl_ir), .core_ir(core_ir));
`default_nettype wire

// ### verification/jtag_probe.sv
// Host probe model that clocks the test port one bit at a time.
`default_nettype none
module jtag_probe (
	input wire logic clk,
	input wire logic tdo,
	output var logic tck,
	output var logic tms,
	output var logic tdi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// The test clock rests low between bits; one bit takes 16 clk, 128 ns.
	task automatic step(input logic m, input logic d, output logic o);
		@(negedge clk);
		tms <= m;
		tdi <= d;
		repeat (7) @(negedge clk);
		o = tdo;
		tck <= 1'b1;
		repeat (8) @(negedge clk);
		tck <= 1'b0;
		tdi <= ~d;
	endtask
endmodule // jtag_probe
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the debug client selection block.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [4:0] top; logic [9:0] cl; int n; logic [2:0] f; logic [13:0] ir;} row_t;
	logic clk = 1'b0, rstn = 1'b0, debug_event = 1'b0;
	logic tck, tms, tdi, tdo, tdo_en, break_request, grant_port_ctrl_tap, grant_core_tap;
	logic port_ctrl_enabled, en_ok;
	logic [3:0] port_ctrl_ir;
	logic [9:0] core_ir, cap;
	int n_errors = 0, compares = 0, cycles = 0, k;
	row_t rows [5] = '{'{5'h10, 10'h000, 4, 3'b101, 14'h007F}, '{5'h10, 10'h00F, 4, 3'b100, 14'h3C7F},
		'{5'h07, 10'h000, 4, 3'b000, 14'h3C7F}, '{5'h11, 10'h07F, 10, 3'b010, 14'h3C7F},
		'{5'h11, 10'h155, 10, 3'b010, 14'h3D55}};
	always #4 clk = ~clk;
	debug_interface_block u_debug_interface_block (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_en(tdo_en), .debug_event(debug_event),
		.break_request(break_request), .grant_port_ctrl_tap(grant_port_ctrl_tap),
		.grant_core_tap(grant_core_tap), .port_ctrl_enabled(port_ctrl_enabled),
		.port_ctrl_ir(port_ctrl_ir), .core_ir(core_ir));
	jtag_probe u_jtag_probe (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
	task automatic chk(input logic ok, input string what);
		compares++;
		if (!ok) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	task automatic go(input logic m);
		logic o;
		u_jtag_probe.step(m, 1'b0, o);
	endtask
	// From Idle: walk to a shift state, shift n bits LSB first, update, back to Idle.
	task automatic scan(input logic ir, input logic [9:0] v, input int n);
		logic o;
		go(1'b1);
		if (ir) go(1'b1);
		go(1'b0);
		go(1'b0);
		en_ok = 1'b1;
		for (int i = 0; i < n; i++) begin
			u_jtag_probe.step(i == n - 1, v[i], o);
			cap[i] = o;
			en_ok = en_ok & (tdo_en === 1'b1);
		end
		go(1'b1);
		go(1'b0);
		repeat (4) @(negedge clk);
	endtask
	task automatic complete_run;
		if (n_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			complete_run;
		end
	end
	initial begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		foreach (rows[r]) begin
			repeat (5) go(1'b1);
			go(1'b0);
			scan(1'b1, {5'h00, rows[r].top}, 5);
			chk({grant_port_ctrl_tap, grant_core_tap} === rows[r].f[2:1], "grant");
			scan(1'b1, rows[r].cl, rows[r].n);
			chk(port_ctrl_enabled === rows[r].f[0], "enable");
			chk({port_ctrl_ir, core_ir} === rows[r].ir, "client ir");
			scan(1'b0, 10'h2CD, 10);
			chk(cap[9:1] === 9'h0CD, "bypass");
			chk(en_ok && tdo_en === 1'b0, "tdo enable");
		end
		@(negedge clk);
		debug_event = 1'b1;
		k = 0;
		while (break_request !== 1'b1 && k < 10) begin
			@(negedge clk);
			k++;
		end
		chk(k < 10, "no break");
		@(negedge clk);
		chk(break_request === 1'b0, "break width");
		debug_event = 1'b0;
		rstn = 1'b0;
		@(negedge clk);
		chk({grant_port_ctrl_tap, grant_core_tap, port_ctrl_enabled} === 3'h0, "reset");
		chk({port_ctrl_ir, core_ir} === 14'h3C7F, "reset ir");
		rstn = 1'b1;
		complete_run;
	end
endmodule // testbench
`default_nettype wire
